// *** wvs_pkg.sv ***
/*
 * Constants shared by the wiper temporary-setting controller and its FIFO.
 * Assumes a 40 MHz core clock.
 */
package wvs_pkg;

	localparam int          WVS_CORE_PERIOD_PS  = 25000;
	localparam int          WVS_COMMIT_STROBE_SETUP_NS   = 150;
	localparam int          WVS_COMMIT_STROBE_SETUP_CYC  = (WVS_COMMIT_STROBE_SETUP_NS * 1000 + WVS_CORE_PERIOD_PS - 1)
	                                              / WVS_CORE_PERIOD_PS;
	localparam int          WVS_DATA_BITS       = 8;
	localparam int          WVS_ADDR_BITS       = 2;
	localparam int          WVS_FIFO_DEPTH      = 8;
	localparam logic [1:0]  WVS_OWN_ADDR        = 2'h1;
	localparam logic [2:0]  WVS_ADDR_LAST       = 3'h1;
	localparam logic [2:0]  WVS_DATA_LAST       = 3'h7;
	localparam logic [2:0]  WVS_CNT_RST         = 3'h0;
	localparam logic [7:0]  WVS_WIPER_RST       = 8'h00;

	typedef enum logic [2:0] {
		WVS_ST_IDLE  = 3'b000,
		WVS_ST_ADDR  = 3'b001,
		WVS_ST_DATA  = 3'b011,
		WVS_ST_APPLY = 3'b010,
		WVS_ST_GAP   = 3'b110
	} wvs_state_t;

endpackage

// *** wvs_stream_if.sv ***
/*
 * Valid/ready word stream between the controller and its FIFO.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface wvs_stream_if #(parameter int WIDTH = 8) ();
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// *** wvs_fifo.sv ***
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two, at least 2.
 */
`timescale 1ns/1ps
module wvs_fifo
	import wvs_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic   clk_in,
	input  wire logic   resetn_in,
	wvs_stream_if.snk   push_in,
	wvs_stream_if.src   pop_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wr_ptr_r;
	logic [AW:0]      rd_ptr_r;

	wire full_w  = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	wire empty_w = (wr_ptr_r == rd_ptr_r);
	wire push_w  = push_in.valid && !full_w;
	wire pop_w   = pop_out.ready && !empty_w;

	assign push_in.ready = !full_w;
	assign pop_out.valid = !empty_w;
	assign pop_out.data  = mem_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push_w) wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop_w)  rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push_w) mem_r[wr_ptr_r[AW-1:0]] <= push_in.data;
	end
endmodule

// *** wvs_ctrl.sv ***
/*
 * Serial control of one 8-bit wiper: temporary loads, reload from the
 * stored value on deselect, and queued commits to the non-volatile cell.
 * Assumes the serial pins are asynchronous to core_clk_in and that the
 * serial clock is well below a quarter of the core clock rate.
 */
// Behaviour
// - Temporary load changes output, not stored value
// - Any number of loads per select period while the commit queue is not full
// - Loaded value holds while select high
// - Select low reloads wiper from stored value
// - Uncommitted data dropped two clocks after receipt
// - Frame: start one, two address, eight data
// - Wiper updates on clock after last data bit
// - Old wiper value shifts out during data
`timescale 1ns/1ps
module wvs_ctrl
	import wvs_pkg::*;
#(
	parameter int FIFO_DEPTH = WVS_FIFO_DEPTH
) (
	input  wire logic       core_clk_in,
	input  wire logic       resetn_in,
	input  wire logic       ser_clk_in,
	input  wire logic       chip_sel_in,
	input  wire logic       serial_in,
	input  wire logic       commit_strobe_in,
	input  wire logic [7:0] nv_value_in,
	input  wire logic       nv_wr_ready_in,
	output logic      [7:0] wiper_out,
	output logic            serial_out,
	output logic            serial_oe_n_out,
	output logic            store_in_progress_n_out,
	output logic            nv_wr_valid_out,
	output logic      [7:0] nv_wr_data_out
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [2:0] sclk_sync_r;
	logic [1:0] cs_sync_r;
	logic [1:0] din_sync_r;
	logic [1:0] commit_strobe_sync_r;

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sclk_sync_r <= 3'h0;
			cs_sync_r   <= 2'h0;
			din_sync_r  <= 2'h0;
			commit_strobe_sync_r <= 2'h0;
		end else begin
			sclk_sync_r <= {sclk_sync_r[1:0], ser_clk_in};
			cs_sync_r   <= {cs_sync_r[0], chip_sel_in};
			din_sync_r  <= {din_sync_r[0], serial_in};
			commit_strobe_sync_r <= {commit_strobe_sync_r[0], commit_strobe_in};
		end
	end

	wire sclk_rise_w = sclk_sync_r[1] && !sclk_sync_r[2];
	wire cs_w        = cs_sync_r[1];
	wire din_w       = din_sync_r[1];
	wire commit_strobe_w      = commit_strobe_sync_r[1];

	////////////////////////////////////////////////////////////////////////
	// Frame decode

	wvs_state_t state_r;
	wvs_state_t state_nxt;
	logic [2:0] cnt_r;
	logic [1:0] addr_r;
	logic [7:0] data_r;
	logic [7:0] out_sh_r;
	logic [7:0] wiper_r;
	logic       commit_strobe_hold_r;
	logic       load_pend_r;

	wvs_stream_if #(.WIDTH(WVS_DATA_BITS)) push_if ();
	wvs_stream_if #(.WIDTH(WVS_DATA_BITS)) pop_if ();

	wire edge_w       = cs_w && sclk_rise_w;
	wire start_w      = edge_w && (state_r == WVS_ST_IDLE) && din_w && push_if.ready;
	wire addr_done_w  = edge_w && (state_r == WVS_ST_ADDR) && (cnt_r == WVS_ADDR_LAST);
	wire data_shift_w = edge_w && (state_r == WVS_ST_DATA);
	wire data_done_w  = data_shift_w && (cnt_r == WVS_DATA_LAST);
	wire addr_ok_w    = (addr_r == WVS_OWN_ADDR);
	wire apply_fire_w = edge_w && (state_r == WVS_ST_APPLY) && addr_ok_w;
	wire commit_w     = apply_fire_w && commit_strobe_w && commit_strobe_hold_r;
	wire gap_done_w   = edge_w && (state_r == WVS_ST_GAP);

	always_comb begin
		state_nxt = state_r;
		if (!cs_w) begin
			state_nxt = WVS_ST_IDLE;
		end else if (sclk_rise_w) begin
			unique case (state_r)
				WVS_ST_IDLE:  if (start_w) state_nxt = WVS_ST_ADDR;
				WVS_ST_ADDR:  if (addr_done_w) state_nxt = WVS_ST_DATA;
				WVS_ST_DATA:  if (data_done_w) state_nxt = WVS_ST_APPLY;
				WVS_ST_APPLY: state_nxt = WVS_ST_GAP;
				WVS_ST_GAP:   state_nxt = WVS_ST_IDLE;
				default:      state_nxt = WVS_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= WVS_ST_IDLE;
			cnt_r   <= WVS_CNT_RST;
		end else begin
			state_r <= state_nxt;
			if (start_w || addr_done_w || !cs_w) cnt_r <= WVS_CNT_RST;
			else if (edge_w) cnt_r <= cnt_r + 3'h1;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			addr_r   <= 2'h0;
			data_r   <= 8'h00;
			out_sh_r <= 8'h00;
		end else begin
			if (edge_w && state_r == WVS_ST_ADDR) addr_r <= {din_w, addr_r[1]};
			if (data_shift_w) data_r <= {din_w, data_r[7:1]};
			if (addr_done_w) out_sh_r <= wiper_r;
			else if (data_shift_w) out_sh_r <= {1'b0, out_sh_r[7:1]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wiper and programming register

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wiper_r     <= WVS_WIPER_RST;
			load_pend_r <= 1'b1;
			commit_strobe_hold_r <= 1'b0;
		end else begin
			load_pend_r <= 1'b0;
			if (load_pend_r || !cs_w) wiper_r <= nv_value_in;
			else if (apply_fire_w) wiper_r <= data_r;
			if (data_done_w) commit_strobe_hold_r <= 1'b1;
			else if (commit_w || gap_done_w || !cs_w) commit_strobe_hold_r <= 1'b0;
		end
	end

	// Committed words queue towards the cell; a full queue refuses new frames
	assign push_if.valid = commit_w;
	assign push_if.data  = data_r;
	assign pop_if.ready  = nv_wr_ready_in;

	wvs_fifo #(
		.WIDTH (WVS_DATA_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in    (core_clk_in),
		.resetn_in (resetn_in),
		.push_in   (push_if),
		.pop_out   (pop_if)
	);

	assign wiper_out               = wiper_r;
	assign serial_out              = out_sh_r[0];
	assign serial_oe_n_out         = !cs_w;
	assign nv_wr_valid_out         = pop_if.valid;
	assign nv_wr_data_out          = pop_if.data;
	assign store_in_progress_n_out = !pop_if.valid && push_if.ready;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	chk_reload_on_deselect: assert property (
		(!cs_w && !load_pend_r) |=> (wiper_out == $past(nv_value_in)))
		else $error("wiper not reloaded while deselected");

	chk_tristate_deselect: assert property (
		!cs_sync_r[1] |-> serial_oe_n_out)
		else $error("serial output driven while deselected");

	chk_apply_after_last: assert property (
		(edge_w && (state_r == WVS_ST_APPLY) && addr_ok_w) |=> (wiper_out == $past(data_r)))
		else $error("wiper not applied after last data bit");

	chk_hold_while_select: assert property (
		(cs_w && !apply_fire_w && !load_pend_r) |=> $stable(wiper_out))
		else $error("temporary wiper changed while selected");

	chk_drop_two_edges: assert property (
		(commit_strobe_hold_r && gap_done_w) |=> !commit_strobe_hold_r)
		else $error("programming register kept past two edges");

	chk_temp_no_commit: assert property (
		(apply_fire_w && !commit_strobe_w) |-> !push_if.valid)
		else $error("temporary load written to storage");

	chk_gap_reopen: assert property (
		gap_done_w |=> (state_r == WVS_ST_IDLE))
		else $error("next frame not accepted after gap");

	chk_frame_start: assert property (
		start_w |=> (state_r == WVS_ST_ADDR) ##0 (cnt_r == WVS_CNT_RST))
		else $error("start bit not taken");

	chk_old_value_out: assert property (
		addr_done_w |=> (serial_out == $past(wiper_r[0])))
		else $error("previous wiper value not shifted out");

endmodule

// *** wvs_host_model.sv ***
/*
 * Host model driving the serial control pins of the wiper controller.
 * Assumes clk_in is the core clock; serial timing is counted in core cycles.
 */
`timescale 1ns/1ps
module wvs_host_model (
	input  wire logic clk_in,
	input  wire logic sdo_in,
	output logic      sclk_out,
	output logic      cs_out,
	output logic      sdi_out,
	output logic      strobe_out
);
	initial begin
		sclk_out = 1'b0;
		cs_out = 1'b0;
		sdi_out = 1'b0;
		strobe_out = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	task automatic wait_c(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic select(input logic v);
		cs_out = v;
		wait_c(6);
	endtask

	// Start, address and data, LSB first; two more rises apply and close the frame
	task automatic send_frame(input logic [1:0] addr, input logic [7:0] data, input logic commit_strobe,
	                          output logic [7:0] rd);
		logic [10:0] fr;
		fr = {data, addr, 1'b1};
		for (int i = 0; i < 13; i++) begin
			sdi_out = (i < 11) ? fr[i] : ~sdi_out;
			if (i == 1) begin
				strobe_out = commit_strobe;
			end
			wait_c(6);
			sclk_out = 1'b1;
			wait_c(6);
			if (i >= 2 && i <= 9) begin
				rd[i-2] = sdo_in;
			end
			sclk_out = 1'b0;
		end
		strobe_out = 1'b0;
	endtask
endmodule

// *** tb_wiper_temp_setting_control.sv ***
/*
 * Self-checking bench for the wiper controller.
 * Assumes the host model on the serial pins and the bench as the storage cell.
 */
`timescale 1ns/1ps
module tb_wiper_temp_setting_control;
	import wvs_pkg::*;
	localparam logic [7:0] NV_VAL = 8'h5A;
	logic       core_clk_in    = 1'b0;
	logic       resetn_in;
	logic       nv_wr_ready_in;
	logic [7:0] nv_value_in;
	logic       sclk, cs, sdi, commit_strobe, sdo, oe_n, busy_n, nv_valid;
	logic [7:0] wiper, nv_data;
	wire        sdo_w = oe_n ? 1'bz : sdo;
	int         err_count = 0;
	int         num_checks = 0;
	int         cycles = 0;

	always #12.5 core_clk_in = ~core_clk_in;

	wvs_host_model host (.clk_in(core_clk_in), .sdo_in(sdo_w), .sclk_out(sclk), .cs_out(cs), .sdi_out(sdi),
		.strobe_out(commit_strobe));

	wvs_ctrl #(.FIFO_DEPTH(WVS_FIFO_DEPTH)) dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
		.ser_clk_in(sclk), .chip_sel_in(cs), .serial_in(sdi), .commit_strobe_in(commit_strobe),
		.nv_value_in(nv_value_in), .nv_wr_ready_in(nv_wr_ready_in), .wiper_out(wiper), .serial_out(sdo),
		.serial_oe_n_out(oe_n), .store_in_progress_n_out(busy_n), .nv_wr_valid_out(nv_valid),
		.nv_wr_data_out(nv_data));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 10000) begin
			err_count++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk(wiper, NV_VAL);
		chk(oe_n, 1'b1);
		$display("t_reset done");
	endtask

	task automatic t_temp();
		logic [7:0] rd;
		host.select(1'b1);
		chk(oe_n, 1'b0);
		host.send_frame(WVS_OWN_ADDR, 8'hA5, 1'b0, rd);
		chk(wiper, 8'hA5);
		chk(rd, NV_VAL);
		chk(nv_valid, 1'b0);
		host.send_frame(WVS_OWN_ADDR, 8'h3C, 1'b0, rd);
		chk(wiper, 8'h3C);
		chk(rd, 8'hA5);
		host.send_frame(2'h2, 8'hFF, 1'b0, rd);
		chk(wiper, 8'h3C);
		host.wait_c(200);
		chk(wiper, 8'h3C);
		chk(busy_n, 1'b1);
		chk(nv_valid, 1'b0);
		host.select(1'b0);
		chk(wiper, NV_VAL);
		chk(oe_n, 1'b1);
		$display("t_temp done");
	endtask

	// Fill the commit queue with the cell stalled, then drain it in order
	task automatic t_commit();
		logic [7:0] rd;
		host.select(1'b1);
		for (int i = 0; i < WVS_FIFO_DEPTH; i++) begin
			host.send_frame(WVS_OWN_ADDR, 8'(8'h10 + i), 1'b1, rd);
			chk(wiper, 8'(8'h10 + i));
			chk(nv_data, 8'h10);
		end
		chk(busy_n, 1'b0);
		chk(nv_valid, 1'b1);
		nv_wr_ready_in = 1'b1;
		for (int i = 0; i < WVS_FIFO_DEPTH; i++) begin
			chk(nv_valid, 1'b1);
			chk(nv_data, 8'(8'h10 + i));
			host.wait_c(1);
		end
		nv_wr_ready_in = 1'b0;
		chk(nv_valid, 1'b0);
		chk(busy_n, 1'b1);
		host.select(1'b0);
		chk(wiper, NV_VAL);
		// Stored value changes while deselected: the wiper must follow it
		nv_value_in = 8'h17;
		host.wait_c(2);
		chk(wiper, 8'h17);
		$display("t_commit done");
	endtask

	initial begin
		resetn_in      = 1'b0;
		nv_wr_ready_in = 1'b0;
		nv_value_in    = NV_VAL;
		host.wait_c(2);
		resetn_in = 1'b1;
		host.wait_c(4);
		t_reset();
		t_temp();
		t_commit();
		wrap_up();
	end
endmodule
